// ### rtl/lbse_map.svh
// Constants for the ladder bit stack evaluator
`ifndef LBSE_MAP_SVH
`define LBSE_MAP_SVH

// -------------------------------------------------------------
// Stack shape
// -------------------------------------------------------------
`define LBSE_STACK_DEPTH 8
`define LBSE_STACK_MSB 7
`define LBSE_STACK_RESET 8'h00
`define LBSE_FILL_BIT 1'b0

// -------------------------------------------------------------
// Bit address layout: area, byte, bit
// -------------------------------------------------------------
`define LBSE_ADDR_W 16
`define LBSE_ADDR_MSB 15
`define LBSE_ADDR_RESET 16'h0000
`define LBSE_AREA_HI 15
`define LBSE_AREA_LO 13
`define LBSE_AREA_W 3

// -------------------------------------------------------------
// Area codes
// -------------------------------------------------------------
`define LBSE_AREA_INPUT 3'h0
`define LBSE_AREA_OUTPUT 3'h1
`define LBSE_AREA_INTERNAL 3'h2

`endif

// ### rtl/lbse_pkg.sv
// Types for the ladder bit stack evaluator
package lbse_pkg;

  // -----------------------------------------------------------
  // Instruction codes
  // -----------------------------------------------------------
  typedef enum logic [3:0] {
    LBSE_OP_IDLE,
    LBSE_OP_LOAD,
    LBSE_OP_LOAD_INV,
    LBSE_OP_DRIVE_COIL,
    LBSE_OP_DRIVE_COIL_INV,
    LBSE_OP_SERIES,
    LBSE_OP_SERIES_INV,
    LBSE_OP_PARALLEL,
    LBSE_OP_PARALLEL_INV,
    LBSE_OP_MERGE_PARALLEL,
    LBSE_OP_MERGE_SERIES
  } lbse_op_t;

  // -----------------------------------------------------------
  // Stack moves
  // -----------------------------------------------------------
  typedef enum logic [1:0] {
    LBSE_STK_HOLD,
    LBSE_STK_PUSH,
    LBSE_STK_REPLACE,
    LBSE_STK_POP
  } lbse_stack_move_t;

endpackage

// ### rtl/lbse_stack.sv
// Bit-wide stack register of the evaluator
`timescale 1ns/1ns
`include "lbse_map.svh"

module lbse_stack
  import lbse_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire lbse_stack_move_t move,
  input wire logic new_top,
  output logic [`LBSE_STACK_MSB:0] stack_image
);

  logic [`LBSE_STACK_MSB:0] next_stack;

  // -----------------------------------------------------------
  // Shift selection
  // -----------------------------------------------------------
  wire [`LBSE_STACK_MSB:0] pushed =
    {stack_image[`LBSE_STACK_MSB-1:0], new_top};
  wire [`LBSE_STACK_MSB:0] replaced =
    {stack_image[`LBSE_STACK_MSB:1], new_top};
  wire [`LBSE_STACK_MSB:0] popped =
    {`LBSE_FILL_BIT, stack_image[`LBSE_STACK_MSB:2], new_top};

  always_comb begin
    case (move)
      LBSE_STK_PUSH: next_stack = pushed;
      LBSE_STK_REPLACE: next_stack = replaced;
      LBSE_STK_POP: next_stack = popped;
      default: next_stack = stack_image;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stack_image <= `LBSE_STACK_RESET;
    end else begin
      stack_image <= next_stack;
    end
  end

endmodule

// ### rtl/lbse_evaluator.sv
// Ladder bit stack evaluator: decode, combine, coil drive
//
// How it works
// - Plain load pushes the stack one deeper, addressed bit on top.
// - Inverted load pushes likewise, complement of addressed bit on top.
// - Plain coil write copies the top entry to the addressed bit.
// - Inverted coil write stores the complement of the top entry.
// - Coil writes target output or internal relays only, never inputs.
// - Consecutive coil writes each drive their own bit from one result.
// - Series replaces top with top AND addressed bit.
// - Any number of consecutive series contacts is accepted.
// - Inverted series replaces top with top AND NOT addressed bit.
// - Parallel replaces top with top OR addressed bit.
// - Inverted parallel replaces top with top OR NOT addressed bit.
// - Parallel contacts combine with the current top entry.
// - Parallel merge ORs top and second, then pops one place.
// - Series merge ANDs top and second, then pops one place.
// - Merges ignore the address and use only stack contents.
// - Each load, contact or merge performs exactly one step on the stack; coil writes hold it.
`timescale 1ns/1ns
`include "lbse_map.svh"

module lbse_evaluator
  import lbse_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire lbse_op_t instr_op,
  input wire logic [`LBSE_ADDR_MSB:0] instr_addr,
  input wire logic operand_bit,
  output logic coil_we,
  output logic [`LBSE_ADDR_MSB:0] coil_addr,
  output logic coil_data,
  output logic coil_refused,
  output logic step_done,
  output logic stack_top,
  output logic stack_second,
  output logic [`LBSE_STACK_MSB:0] stack_image
);

  // -----------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------
  function automatic logic [`LBSE_AREA_W-1:0] area_of(
    input logic [`LBSE_ADDR_MSB:0] addr
  );
    area_of = addr[`LBSE_AREA_HI:`LBSE_AREA_LO];
  endfunction

  function automatic logic coil_area_ok(
    input logic [`LBSE_ADDR_MSB:0] addr
  );
    coil_area_ok = (area_of(addr) == `LBSE_AREA_OUTPUT) ||
                   (area_of(addr) == `LBSE_AREA_INTERNAL);
  endfunction

  // -----------------------------------------------------------
  // Decode
  // -----------------------------------------------------------
  wire top = stack_image[0];
  wire second = stack_image[1];
  wire op_load = instr_valid && (instr_op == LBSE_OP_LOAD);
  wire op_load_inv = instr_valid && (instr_op == LBSE_OP_LOAD_INV);
  wire op_coil = instr_valid && (instr_op == LBSE_OP_DRIVE_COIL);
  wire op_coil_inv = instr_valid && (instr_op == LBSE_OP_DRIVE_COIL_INV);
  wire op_ser = instr_valid && (instr_op == LBSE_OP_SERIES);
  wire op_ser_inv = instr_valid && (instr_op == LBSE_OP_SERIES_INV);
  wire op_par = instr_valid && (instr_op == LBSE_OP_PARALLEL);
  wire op_par_inv = instr_valid && (instr_op == LBSE_OP_PARALLEL_INV);
  wire op_mpar = instr_valid && (instr_op == LBSE_OP_MERGE_PARALLEL);
  wire op_mser = instr_valid && (instr_op == LBSE_OP_MERGE_SERIES);
  wire any_coil = op_coil || op_coil_inv;
  wire coil_ok = coil_area_ok(instr_addr);
  wire known_op = op_load || op_load_inv || any_coil || op_ser ||
                  op_ser_inv || op_par || op_par_inv || op_mpar || op_mser;

  // -----------------------------------------------------------
  // Combine
  // -----------------------------------------------------------
  wire load_val = op_load_inv ? ~operand_bit : operand_bit;
  wire ser_val =
    top & (op_ser_inv ? ~operand_bit : operand_bit);
  wire par_val =
    top | (op_par_inv ? ~operand_bit : operand_bit);
  wire mpar_val = top | second;
  wire mser_val = top & second;
  wire coil_val = op_coil_inv ? ~top : top;

  lbse_stack_move_t move;
  logic new_top;

  always_comb begin
    move = LBSE_STK_HOLD;
    new_top = top;
    if (op_load || op_load_inv) begin
      move = LBSE_STK_PUSH;
      new_top = load_val;
    end else if (op_ser || op_ser_inv) begin
      move = LBSE_STK_REPLACE;
      new_top = ser_val;
    end else if (op_par || op_par_inv) begin
      move = LBSE_STK_REPLACE;
      new_top = par_val;
    end else if (op_mpar) begin
      move = LBSE_STK_POP;
      new_top = mpar_val;
    end else if (op_mser) begin
      move = LBSE_STK_POP;
      new_top = mser_val;
    end
  end

  lbse_stack u_stack (
    .clk(clk),
    .resetn(resetn),
    .move(move),
    .new_top(new_top),
    .stack_image(stack_image)
  );

  // -----------------------------------------------------------
  // Coil drive and status
  // -----------------------------------------------------------
  wire next_coil_we = any_coil && coil_ok;
  wire next_coil_refused = any_coil && !coil_ok;
  wire next_top = (move == LBSE_STK_HOLD) ? top : new_top;
  wire next_second = (move == LBSE_STK_PUSH) ? top :
                     (move == LBSE_STK_POP) ? stack_image[2] : second;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      coil_we <= 1'b0;
      coil_addr <= `LBSE_ADDR_RESET;
      coil_data <= 1'b0;
      coil_refused <= 1'b0;
      step_done <= 1'b0;
    end else begin
      coil_we <= next_coil_we;
      coil_refused <= next_coil_refused;
      step_done <= known_op;
      if (any_coil) begin
        coil_addr <= instr_addr;
        coil_data <= coil_val;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stack_top <= 1'b0;
      stack_second <= 1'b0;
    end else begin
      stack_top <= next_top;
      stack_second <= next_second;
    end
  end

  // -----------------------------------------------------------
  // Checks
  // -----------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  chk_load_push: assert property (
    op_load |=> stack_image ==
      {$past(stack_image[`LBSE_STACK_MSB-1:0]), $past(operand_bit)})
    else $error("plain load did not push addressed bit");

  chk_load_inv_push: assert property (
    op_load_inv |=> stack_image ==
      {$past(stack_image[`LBSE_STACK_MSB-1:0]), !$past(operand_bit)})
    else $error("inverted load did not push complement");

  chk_coil_copy: assert property (
    op_coil && coil_ok |=> coil_we && coil_data == $past(top) &&
      coil_addr == $past(instr_addr))
    else $error("coil write did not copy top entry");

  chk_coil_inv_copy: assert property (
    op_coil_inv && coil_ok |=> coil_we && coil_data == !$past(top))
    else $error("inverted coil write did not store complement");

  chk_input_refused: assert property (
    any_coil && area_of(instr_addr) == `LBSE_AREA_INPUT
      |=> !coil_we && coil_refused)
    else $error("coil write reached an input relay");

  sequence coil_pair_s;
    op_coil && coil_ok ##1 op_coil && coil_ok;
  endsequence

  chk_multi_coil: assert property (
    coil_pair_s |=> coil_we && coil_data == $past(coil_data) &&
      $stable(stack_image))
    else $error("second coil did not reuse the same result");

  chk_series: assert property (
    op_ser |=> stack_image[0] == ($past(top) && $past(operand_bit)) &&
      stack_image[`LBSE_STACK_MSB:1] ==
      $past(stack_image[`LBSE_STACK_MSB:1]))
    else $error("series contact result wrong");

  chk_series_run: assert property (
    op_ser [*3] |=> step_done && stack_image[0] == ($past(top, 3) &&
      $past(operand_bit, 3) && $past(operand_bit, 2) &&
      $past(operand_bit)))
    else $error("series contact run result wrong");

  chk_series_inv: assert property (
    op_ser_inv |=> stack_image[0] == ($past(top) && !$past(operand_bit)))
    else $error("inverted series result wrong");

  chk_parallel: assert property (
    op_par |=> stack_image[0] == ($past(top) || $past(operand_bit)))
    else $error("parallel contact result wrong");

  chk_parallel_inv: assert property (
    op_par_inv |=> stack_image[0] == ($past(top) || !$past(operand_bit)))
    else $error("inverted parallel result wrong");

  chk_merge_par: assert property (
    op_mpar |=> stack_image == {`LBSE_FILL_BIT,
      $past(stack_image[`LBSE_STACK_MSB:2]),
      $past(stack_image[0]) || $past(stack_image[1])})
    else $error("parallel merge wrong");

  chk_merge_ser: assert property (
    op_mser |=> stack_image == {`LBSE_FILL_BIT,
      $past(stack_image[`LBSE_STACK_MSB:2]),
      $past(stack_image[0]) && $past(stack_image[1])})
    else $error("series merge wrong");

  chk_one_step: assert property (
    !instr_valid |=> !step_done && !coil_we &&
      stack_image == $past(stack_image))
    else $error("stack moved without an instruction");

  chk_top_mirror: assert property (
    stack_top == stack_image[0] && stack_second == stack_image[1])
    else $error("top outputs disagree with stack");

  cov_branch_join: cover property (
    op_load ##1 op_load ##1 op_mpar ##1 op_coil);

  cov_series_group: cover property (
    op_load ##1 op_par ##1 op_load ##1 op_par ##1 op_mser);

  cov_coil_refused: cover property (next_coil_refused);

  cov_deep_push: cover property (op_load [*8] ##1 op_load);

endmodule

// ### verif/lbse_signal_memory.sv
// Signal memory model feeding contact states and taking coil writes
`timescale 1ns/1ns
`include "lbse_map.svh"

module lbse_signal_memory (
  input wire logic clk,
  input wire logic [`LBSE_ADDR_MSB:0] rd_addr,
  input wire logic wr_en,
  input wire logic [`LBSE_ADDR_MSB:0] wr_addr,
  input wire logic wr_data,
  output logic rd_bit
);
  // ---------------------------------------------------------
  // Storage, preset to the parity of the low address byte
  // ---------------------------------------------------------
  logic mem [0:255];

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = ^i[7:0];
    end
  end

  assign rd_bit = mem[rd_addr[7:0]];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr[7:0]] <= wr_data;
    end
  end
endmodule

// ### verif/ladder_bit_stack_evaluator_test.sv
// Self-checking bench for the ladder bit stack evaluator
`timescale 1ns/1ns
`include "lbse_map.svh"

module ladder_bit_stack_evaluator_test import lbse_pkg::*;;
  typedef struct {
    lbse_op_t op;
    logic [15:0] addr;
    logic [7:0] img;
    logic [1:0] cc;
  } lbse_row_t;

  localparam logic [15:0] A0 = 16'h0000;
  localparam logic [15:0] A1 = 16'h0001;
  localparam logic [15:0] YC = 16'h2010;
  localparam logic [15:0] RC = 16'h4020;

  logic clk;
  logic resetn;
  logic instr_valid;
  lbse_op_t instr_op;
  logic [15:0] instr_addr;
  logic operand_bit;
  logic coil_we;
  logic [15:0] coil_addr;
  logic coil_data;
  logic coil_refused;
  logic step_done;
  logic stack_top;
  logic stack_second;
  logic [7:0] stack_image;
  int fails;
  int n_checks;

  // ---------------------------------------------------------
  // Ordinary cases: op, address, stack after, coil we/data
  // ---------------------------------------------------------
  lbse_row_t rows [19] = '{
    '{LBSE_OP_LOAD, A1, 8'h01, 2'h0},
    '{LBSE_OP_LOAD_INV, A1, 8'h02, 2'h0},
    '{LBSE_OP_LOAD_INV, A0, 8'h05, 2'h0},
    '{LBSE_OP_SERIES, A1, 8'h05, 2'h0},
    '{LBSE_OP_SERIES, A0, 8'h04, 2'h0},
    '{LBSE_OP_SERIES_INV, A0, 8'h04, 2'h0},
    '{LBSE_OP_PARALLEL, A1, 8'h05, 2'h0},
    '{LBSE_OP_SERIES_INV, A1, 8'h04, 2'h0},
    '{LBSE_OP_PARALLEL_INV, A0, 8'h05, 2'h0},
    '{LBSE_OP_PARALLEL, A0, 8'h05, 2'h0},
    '{LBSE_OP_MERGE_PARALLEL, A1, 8'h03, 2'h0},
    '{LBSE_OP_MERGE_SERIES, A0, 8'h01, 2'h0},
    '{LBSE_OP_LOAD, A0, 8'h02, 2'h0},
    '{LBSE_OP_MERGE_SERIES, A1, 8'h00, 2'h0},
    '{LBSE_OP_DRIVE_COIL, YC, 8'h00, 2'h2},
    '{LBSE_OP_DRIVE_COIL_INV, RC, 8'h00, 2'h3},
    '{LBSE_OP_LOAD, YC, 8'h00, 2'h0},
    '{LBSE_OP_LOAD, RC, 8'h01, 2'h0},
    '{LBSE_OP_IDLE, A1, 8'h01, 2'h0}
  };

  lbse_evaluator u_dut (
    .clk(clk),
    .resetn(resetn),
    .instr_valid(instr_valid),
    .instr_op(instr_op),
    .instr_addr(instr_addr),
    .operand_bit(operand_bit),
    .coil_we(coil_we),
    .coil_addr(coil_addr),
    .coil_data(coil_data),
    .coil_refused(coil_refused),
    .step_done(step_done),
    .stack_top(stack_top),
    .stack_second(stack_second),
    .stack_image(stack_image)
  );

  lbse_signal_memory u_mem (
    .clk(clk),
    .rd_addr(instr_addr),
    .wr_en(coil_we),
    .wr_addr(coil_addr),
    .wr_data(coil_data),
    .rd_bit(operand_bit)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk1(logic e, logic g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t exp %0h got %0h", $time, e, g);
    end
  endtask

  task automatic chk8(logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t exp %0h got %0h", $time, e, g);
    end
  endtask

  task automatic chk16(logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t exp %0h got %0h", $time, e, g);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic put(logic v, lbse_op_t op, logic [15:0] a);
    instr_valid = v;
    instr_op = op;
    instr_addr = a;
  endtask

  task automatic check_row(lbse_row_t r);
    chk8(r.img, stack_image);
    chk1(r.img[0], stack_top);
    chk1(r.img[1], stack_second);
    chk1(r.op != LBSE_OP_IDLE, step_done);
    chk1(r.cc[1], coil_we);
    chk1(1'b0, coil_refused);
    if (r.cc[1]) chk1(r.cc[0], coil_data);
    if (r.cc[1]) chk16(r.addr, coil_addr);
  endtask

  initial begin
    #100000;
    fails++;
    conclude();
  end

  initial begin
    fails = 0;
    n_checks = 0;
    resetn = 1'b0;
    put(1'b0, LBSE_OP_IDLE, A0);
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk8(8'h00, stack_image);
    chk1(1'b0, step_done);
    // Rows back to back; later blocks open with a coil write, a series contact and a load
    for (int i = 0; i <= 19; i++) begin
      tick();
      if (i > 0) check_row(rows[i-1]);
      if (i < 19) put(1'b1, rows[i].op, rows[i].addr);
    end
    // Coil write aimed at an input bit
    put(1'b1, LBSE_OP_DRIVE_COIL, 16'h0005);
    tick();
    put(1'b0, LBSE_OP_LOAD, A1);
    chk1(1'b1, coil_refused);
    chk1(1'b0, coil_we);
    chk8(8'h01, stack_image);
    tick();
    chk8(8'h01, stack_image);
    chk1(1'b0, step_done);
    // Series run, then two coils from one result
    put(1'b1, LBSE_OP_SERIES, A1);
    tick();
    put(1'b1, LBSE_OP_SERIES, A1);
    tick();
    chk1(1'b1, stack_top);
    put(1'b1, LBSE_OP_SERIES, A0);
    tick();
    chk8(8'h00, stack_image);
    put(1'b1, LBSE_OP_DRIVE_COIL, YC);
    tick();
    put(1'b1, LBSE_OP_DRIVE_COIL, RC);
    chk1(1'b1, coil_we);
    chk16(YC, coil_addr);
    tick();
    chk1(1'b1, coil_we);
    chk1(1'b0, coil_data);
    chk16(RC, coil_addr);
    chk8(8'h00, stack_image);
    // Overfill then merge twice
    for (int k = 0; k < 9; k++) begin
      put(1'b1, LBSE_OP_LOAD, A1);
      tick();
    end
    chk8(8'hFF, stack_image);
    put(1'b1, LBSE_OP_MERGE_SERIES, A0);
    tick();
    chk8(8'h7F, stack_image);
    put(1'b1, LBSE_OP_MERGE_PARALLEL, A0);
    tick();
    chk8(8'h3F, stack_image);
    put(1'b0, LBSE_OP_IDLE, A0);
    resetn = 1'b0;
    tick();
    chk8(8'h00, stack_image);
    chk1(1'b0, step_done);
    chk16(A0, coil_addr);
    resetn = 1'b1;
    tick();
    chk8(8'h00, stack_image);
    chk1(1'b0, step_done);
    conclude();
  end
endmodule
